// ---- inc/pac_cfg.svh ----
// register offsets, field widths, reset values and timing counts of the port block
// assumes: included by bare name from the package and the design modules
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

`define PAC_ADDR_W 6
`define PAC_DATA_W 32
`define PAC_PORT_W 16
`define PAC_ANA_W 32
`define PAC_CHG_W 24
`define PAC_SYNC_STAGES 2

`define PAC_OFS_DIR 6'h00
`define PAC_OFS_PORT 6'h04
`define PAC_OFS_LATCH 6'h08
`define PAC_OFS_ANA1_LOW 6'h0c
`define PAC_OFS_ANA1_HIGH 6'h10
`define PAC_OFS_ANA2_LOW 6'h14
`define PAC_OFS_ANA2_HIGH 6'h18
`define PAC_OFS_CNEN_LOW 6'h1c
`define PAC_OFS_CNEN_HIGH 6'h20
`define PAC_OFS_PU_LOW 6'h24
`define PAC_OFS_PU_HIGH 6'h28
`define PAC_OFS_CHG_STAT 6'h2c

`define PAC_RST_DIR 16'hffff
`define PAC_RST_LATCH 16'h0000
`define PAC_RST_ANA 16'h0000
`define PAC_RST_CNEN 16'h0000
`define PAC_RST_PU 16'h0000
`define PAC_CHG_HIGH_W 8
`define PAC_CHG_FLAG_BIT 0

`endif

// ---- inc/pac_pkg.sv ----
// types shared by the port block modules
// assumes: pac_cfg.svh on the include path
`include "pac_cfg.svh"

package pac_pkg;
    typedef logic [`PAC_PORT_W-1:0] pac_word_t;
    typedef enum {
        PAC_SEL_DIR, PAC_SEL_PORT, PAC_SEL_LATCH, PAC_SEL_ANA1_LOW, PAC_SEL_ANA1_HIGH,
        PAC_SEL_ANA2_LOW, PAC_SEL_ANA2_HIGH, PAC_SEL_CNEN_LOW, PAC_SEL_CNEN_HIGH,
        PAC_SEL_PU_LOW, PAC_SEL_PU_HIGH, PAC_SEL_CHG_STAT, PAC_SEL_NONE
    } pac_sel_e;
    typedef enum {PAC_BUS_IDLE, PAC_BUS_ANSWER} pac_bus_e;
endpackage : pac_pkg

// ---- src/pac_sync.sv ----
// two flip-flop synchroniser for pin levels
// assumes: inputs are asynchronous to clk; output lags the pin by two edges
`timescale 1ns/10ps

module pac_sync
    import pac_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;

endmodule : pac_sync

// ---- src/pac_chg_notify.sv ----
// change-of-state detector with sticky request flag
// assumes: levels already synchronised; clear is a one-cycle pulse
`timescale 1ns/10ps
`include "pac_cfg.svh"

module pac_chg_notify
    import pac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // inputs and controls
    input wire logic [`PAC_CHG_W-1:0] level,
    input wire logic [`PAC_CHG_W-1:0] irqEnable,
    input wire logic flagClear,
    // results
    output logic [`PAC_CHG_W-1:0] captured,
    output logic flag
);

    logic [`PAC_CHG_W-1:0] captured_ff;
    logic flag_ff;
    logic hit;

    assign hit = |((level ^ captured_ff) & irqEnable);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            captured_ff <= '0;
        end else begin
            captured_ff <= level;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= 1'b0;
        end else if (hit) begin
            flag_ff <= 1'b1;
        end else if (flagClear) begin
            flag_ff <= 1'b0;
        end
    end

    assign captured = captured_ff;
    assign flag = flag_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_change_sets_flag: assert property (hit |=> flag)
        else $error("enabled change did not set the flag");
    a_disabled_no_set: assert property (!hit && !flag |=> !flag)
        else $error("flag rose without an enabled change");
    a_flag_sticky: assert property (flag && !flagClear |=> flag [*2] or (flag ##1 !flag && $past(flagClear)))
        else $error("flag dropped without a clear");
    c_flag_rise: cover property (!flag ##1 flag);

endmodule : pac_chg_notify

// ---- src/pac_top.sv ----
// port block with analog pin selection and input change notification
// assumes: Avalon-MM master on clk; pins and change inputs are asynchronous
// What this block does
// - A cleared analog select bit makes the pin analog, a set bit in both modules makes it digital.
// - Analog select bits reset cleared, so analog-capable pins start as analog.
// - With two converter modules a pin is analog if either module's select bit is cleared.
// - Port reads return zero in every bit whose pin is analog.
// - A digital pin is not routed to the converter.
// - Enabled input changes request an interrupt.
// - Up to 24 change inputs, numbered 0 to 23, are supported.
// - Each change input has its own enable bit in one of two enable registers.
// - Each change input has a weak pull-up enable bit in one of two pull-up registers.
// - A direction bit of one makes the pin an input, and all pins are inputs after reset.
// - Port reads return pin levels, port writes update the latch, latch accesses reach the latch.
`timescale 1ns/10ps
`include "pac_cfg.svh"

module pac_top
    import pac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [`PAC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [`PAC_DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [`PAC_DATA_W-1:0] readdata,
    output logic waitrequest,
    // port pins
    input wire logic [`PAC_PORT_W-1:0] pinIn,
    output logic [`PAC_PORT_W-1:0] pinOut,
    output logic [`PAC_PORT_W-1:0] pinOe,
    // analog routing, one bit per analog channel
    output logic [`PAC_ANA_W-1:0] analogMode,
    // change notification
    input wire logic [`PAC_CHG_W-1:0] chgIn,
    output logic [`PAC_CHG_W-1:0] weakPullupEn,
    output logic changeNotifyReq
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic pac_sel_e regSel(input logic [`PAC_ADDR_W-1:0] a);
        case (a)
            `PAC_OFS_DIR: regSel = PAC_SEL_DIR;
            `PAC_OFS_PORT: regSel = PAC_SEL_PORT;
            `PAC_OFS_LATCH: regSel = PAC_SEL_LATCH;
            `PAC_OFS_ANA1_LOW: regSel = PAC_SEL_ANA1_LOW;
            `PAC_OFS_ANA1_HIGH: regSel = PAC_SEL_ANA1_HIGH;
            `PAC_OFS_ANA2_LOW: regSel = PAC_SEL_ANA2_LOW;
            `PAC_OFS_ANA2_HIGH: regSel = PAC_SEL_ANA2_HIGH;
            `PAC_OFS_CNEN_LOW: regSel = PAC_SEL_CNEN_LOW;
            `PAC_OFS_CNEN_HIGH: regSel = PAC_SEL_CNEN_HIGH;
            `PAC_OFS_PU_LOW: regSel = PAC_SEL_PU_LOW;
            `PAC_OFS_PU_HIGH: regSel = PAC_SEL_PU_HIGH;
            `PAC_OFS_CHG_STAT: regSel = PAC_SEL_CHG_STAT;
            default: regSel = PAC_SEL_NONE;
        endcase
    endfunction : regSel

    // merge the two low byte lanes into a 16-bit register
    function automatic pac_word_t laneMerge(input pac_word_t old, input logic [`PAC_DATA_W-1:0] wd,
                                            input logic [3:0] be);
        laneMerge = old;
        if (be[0]) begin
            laneMerge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            laneMerge[15:8] = wd[15:8];
        end
    endfunction : laneMerge

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the access completes

    pac_bus_e busState_ff;
    pac_sel_e sel;
    logic wrAcc;
    logic rdAcc;

    assign sel = regSel(address);
    assign waitrequest = (read || write) && (busState_ff == PAC_BUS_IDLE);
    assign wrAcc = write && (busState_ff == PAC_BUS_ANSWER);
    assign rdAcc = read && (busState_ff == PAC_BUS_ANSWER);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busState_ff <= PAC_BUS_IDLE;
        end else begin
            case (busState_ff)
                PAC_BUS_IDLE: begin
                    if (read || write) begin
                        busState_ff <= PAC_BUS_ANSWER;
                    end
                end
                PAC_BUS_ANSWER: busState_ff <= PAC_BUS_IDLE;
                default: busState_ff <= PAC_BUS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    pac_word_t dir_ff;
    pac_word_t latch_ff;
    pac_word_t ana1Low_ff;
    pac_word_t ana1High_ff;
    pac_word_t ana2Low_ff;
    pac_word_t ana2High_ff;
    pac_word_t chgEnLow_ff;
    logic [`PAC_CHG_HIGH_W-1:0] chgEnHigh_ff;
    pac_word_t puLow_ff;
    logic [`PAC_CHG_HIGH_W-1:0] puHigh_ff;
    pac_word_t nxt_chgEnHigh;
    pac_word_t nxt_puHigh;

    assign nxt_chgEnHigh = laneMerge({8'h00, chgEnHigh_ff}, writedata, byteenable);
    assign nxt_puHigh = laneMerge({8'h00, puHigh_ff}, writedata, byteenable);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_ff <= `PAC_RST_DIR;
        end else if (wrAcc && sel == PAC_SEL_DIR) begin
            dir_ff <= laneMerge(dir_ff, writedata, byteenable);
        end
    end

    // a write to the port lands in the latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_ff <= `PAC_RST_LATCH;
        end else if (wrAcc && (sel == PAC_SEL_PORT || sel == PAC_SEL_LATCH)) begin
            latch_ff <= laneMerge(latch_ff, writedata, byteenable);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ana1Low_ff <= `PAC_RST_ANA;
            ana1High_ff <= `PAC_RST_ANA;
            ana2Low_ff <= `PAC_RST_ANA;
            ana2High_ff <= `PAC_RST_ANA;
        end else if (wrAcc) begin
            case (sel)
                PAC_SEL_ANA1_LOW: ana1Low_ff <= laneMerge(ana1Low_ff, writedata, byteenable);
                PAC_SEL_ANA1_HIGH: ana1High_ff <= laneMerge(ana1High_ff, writedata, byteenable);
                PAC_SEL_ANA2_LOW: ana2Low_ff <= laneMerge(ana2Low_ff, writedata, byteenable);
                PAC_SEL_ANA2_HIGH: ana2High_ff <= laneMerge(ana2High_ff, writedata, byteenable);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chgEnLow_ff <= `PAC_RST_CNEN;
            chgEnHigh_ff <= `PAC_CHG_HIGH_W'(`PAC_RST_CNEN);
            puLow_ff <= `PAC_RST_PU;
            puHigh_ff <= `PAC_CHG_HIGH_W'(`PAC_RST_PU);
        end else if (wrAcc) begin
            case (sel)
                PAC_SEL_CNEN_LOW: chgEnLow_ff <= laneMerge(chgEnLow_ff, writedata, byteenable);
                PAC_SEL_CNEN_HIGH: chgEnHigh_ff <= nxt_chgEnHigh[`PAC_CHG_HIGH_W-1:0];
                PAC_SEL_PU_LOW: puLow_ff <= laneMerge(puLow_ff, writedata, byteenable);
                PAC_SEL_PU_HIGH: puHigh_ff <= nxt_puHigh[`PAC_CHG_HIGH_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin side

    pac_word_t pinSync;
    pac_word_t portView;
    logic [`PAC_ANA_W-1:0] digitalSel;

    // the two-edge sync lag is why a read needs a spare cycle after a write
    pac_sync #(.W(`PAC_PORT_W)) uPinSync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // analog when either module's select bit is cleared
    assign digitalSel = {ana1High_ff & ana2High_ff, ana1Low_ff & ana2Low_ff};
    assign analogMode = ~digitalSel;

    generate
        for (genvar i = 0; i < `PAC_PORT_W; i++) begin : gPortBit
            assign portView[i] = pinSync[i] & digitalSel[i];
        end
    endgenerate

    // output driver stays on for an analog pin left as output
    assign pinOut = latch_ff;
    assign pinOe = ~dir_ff;

    ////////////////////////////////////////////////////////////////////////////
    // change notification

    logic [`PAC_CHG_W-1:0] chgSync;
    logic [`PAC_CHG_W-1:0] chgEnable;
    logic chgFlag;
    logic chgClear;

    pac_sync #(.W(`PAC_CHG_W)) uChgSync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(chgIn),
        .syncOut(chgSync)
    );

    assign chgEnable = {chgEnHigh_ff, chgEnLow_ff};
    assign chgClear = wrAcc && (sel == PAC_SEL_CHG_STAT) && byteenable[0] && writedata[`PAC_CHG_FLAG_BIT];

    pac_chg_notify uChgNotify (
        .clk(clk),
        .rst_b(rst_b),
        .level(chgSync),
        .irqEnable(chgEnable),
        .flagClear(chgClear),
        .captured(),
        .flag(chgFlag)
    );

    assign changeNotifyReq = chgFlag;
    assign weakPullupEn = {puHigh_ff, puLow_ff};

    ////////////////////////////////////////////////////////////////////////////
    // read data

    pac_word_t nxt_readdata;
    logic [`PAC_DATA_W-1:0] readdata_ff;

    always_comb begin
        case (sel)
            PAC_SEL_DIR: nxt_readdata = dir_ff;
            PAC_SEL_PORT: nxt_readdata = portView;
            PAC_SEL_LATCH: nxt_readdata = latch_ff;
            PAC_SEL_ANA1_LOW: nxt_readdata = ana1Low_ff;
            PAC_SEL_ANA1_HIGH: nxt_readdata = ana1High_ff;
            PAC_SEL_ANA2_LOW: nxt_readdata = ana2Low_ff;
            PAC_SEL_ANA2_HIGH: nxt_readdata = ana2High_ff;
            PAC_SEL_CNEN_LOW: nxt_readdata = chgEnLow_ff;
            PAC_SEL_CNEN_HIGH: nxt_readdata = {8'h00, chgEnHigh_ff};
            PAC_SEL_PU_LOW: nxt_readdata = puLow_ff;
            PAC_SEL_PU_HIGH: nxt_readdata = {8'h00, puHigh_ff};
            PAC_SEL_CHG_STAT: nxt_readdata = {15'h0, chgFlag};
            default: nxt_readdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata_ff <= 32'h00000000;
        end else if (read && busState_ff == PAC_BUS_IDLE) begin
            readdata_ff <= {16'h0000, nxt_readdata};
        end
    end

    assign readdata = readdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_port_analog_zero: assert property (rdAcc && sel == PAC_SEL_PORT
        |-> (readdata[15:0] & ~digitalSel[15:0]) == 16'h0000)
        else $error("analog pin read as one through the port");
    a_ana_either_module: assert property (wrAcc && sel == PAC_SEL_ANA2_LOW && byteenable[0] && !writedata[0]
        |=> analogMode[0])
        else $error("cleared second-module bit did not make the pin analog");
    a_ana_digital: assert property (wrAcc && sel == PAC_SEL_ANA1_LOW && byteenable[0] && writedata[0]
        && ana2Low_ff[0] |=> !analogMode[0])
        else $error("set select bits did not make the pin digital");
    a_port_write_latch: assert property (wrAcc && sel == PAC_SEL_PORT && byteenable[0]
        |=> pinOut[7:0] == $past(writedata[7:0]))
        else $error("port write did not reach the latch");
    a_dir_holds_input: assert property (!pinOe[0] && !(wrAcc && sel == PAC_SEL_DIR) |=> !pinOe[0])
        else $error("pin turned to output without a direction write");
    a_pullup_write: assert property (wrAcc && sel == PAC_SEL_PU_HIGH && byteenable[0]
        |=> weakPullupEn[23:16] == $past(writedata[7:0]))
        else $error("pull-up enable not updated");
    a_chg_request: assert property (((chgSync ^ $past(chgSync)) & chgEnable) != 24'h000000
        |-> ##[0:1] changeNotifyReq)
        else $error("enabled change raised no request");
    c_write_done: cover property (wrAcc);
    c_port_read: cover property (rdAcc && sel == PAC_SEL_PORT);
    c_chg_clear: cover property (changeNotifyReq ##1 chgClear ##1 !changeNotifyReq);

endmodule : pac_top

// ---- sim/pac_pin_model.sv ----
// pin-side model: external pin levels, push buttons on the change inputs, weak pull-ups
// assumes: bench sets extLevel and btnPress; shares clk with the port block
`timescale 1ns/10ps
`include "pac_cfg.svh"

module pac_pin_model (
    // clock
    input wire logic clk,
    // port block side
    input wire logic [`PAC_PORT_W-1:0] pinOut,
    input wire logic [`PAC_PORT_W-1:0] pinOe,
    input wire logic [`PAC_CHG_W-1:0] weakPullupEn,
    output logic [`PAC_PORT_W-1:0] pinIn,
    output logic [`PAC_CHG_W-1:0] chgIn,
    // bench controls
    input wire logic [`PAC_PORT_W-1:0] extLevel,
    input wire logic [`PAC_CHG_W-1:0] btnPress
);
    logic [`PAC_CHG_W-1:0] floatPat;

    // an input with neither button nor pull-up wanders every cycle
    initial floatPat = '0;
    always @(posedge clk) floatPat <= ~floatPat;
    // a driven pin reads back its own output level, others the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
    // a pressed button shorts the line low
    assign chgIn = ~btnPress & (weakPullupEn | floatPat);
endmodule : pac_pin_model

// ---- sim/port_analog_cfg_change_notify_tb_top.sv ----
// self-checking bench for the port block: register accesses over avalon-mm, pins and change inputs
// assumes: pac_cfg.svh on the include path; pin model on the far side
`timescale 1ns/10ps
`include "pac_cfg.svh"

module port_analog_cfg_change_notify_tb_top;
    logic clk, rst_b, read, write, waitrequest, changeNotifyReq;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [15:0] pinIn, pinOut, pinOe, extLevel;
    logic [31:0] analogMode;
    logic [23:0] chgIn, weakPullupEn, btnPress, mask;
    int miscompares, totalChecks;
    int chgIdx[5] = '{0, 7, 15, 16, 23};

    ////////////////////////////////////////////////////////////////////////////
    pac_top pac_top_inst (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .analogMode(analogMode), .chgIn(chgIn),
        .weakPullupEn(weakPullupEn), .changeNotifyReq(changeNotifyReq));
    pac_pin_model pac_pin_model_inst (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .weakPullupEn(weakPullupEn),
        .pinIn(pinIn), .chgIn(chgIn), .extLevel(extLevel), .btnPress(btnPress));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one bus cycle; request held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [5:0] addr, input logic [15:0] data,
                          input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        address <= addr;
        writedata <= {16'h0000, data};
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                miscompares++;
                complete_run();
            end
            @(posedge clk);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : access

    task automatic wr(input logic [5:0] addr, input logic [15:0] data);
        logic [31:0] unused;
        access(1'b1, addr, data, 4'h3, unused);
    endtask : wr

    task automatic rdchk(input logic [5:0] addr, input logic [31:0] exp);
        logic [31:0] v;
        access(1'b0, addr, 16'h0000, 4'h3, v);
        check(v, exp);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        byteenable = 4'h0;
        extLevel = 16'ha5a5;
        btnPress = 24'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check(32'(pinOe), 32'h0);
        check(analogMode, 32'hffffffff);
        check(32'(weakPullupEn), 32'h0);
        check(32'(changeNotifyReq), 32'h0);
        rdchk(`PAC_OFS_DIR, 32'hffff);
        for (int i = 0; i < 4; i++) begin
            rdchk(6'(`PAC_OFS_ANA1_LOW + 4 * i), 32'h0);
        end
        rdchk(`PAC_OFS_PORT, 32'h0);
        // analog when either converter's select bit is clear
        wr(`PAC_OFS_ANA1_LOW, 16'hffff);
        wr(`PAC_OFS_ANA2_LOW, 16'h00ff);
        check(32'(analogMode[15:0]), 32'hff00);
        rdchk(`PAC_OFS_PORT, 32'h00a5);
        wr(`PAC_OFS_ANA2_LOW, 16'hffff);
        check(32'(analogMode[15:0]), 32'h0);
        rdchk(`PAC_OFS_PORT, 32'ha5a5);
        wr(`PAC_OFS_ANA1_HIGH, 16'h0f0f);
        wr(`PAC_OFS_ANA2_HIGH, 16'hffff);
        check(32'(analogMode[31:16]), 32'hf0f0);
        // low byte pins become outputs
        wr(`PAC_OFS_DIR, 16'hff00);
        wr(`PAC_OFS_PORT, 16'h003c);
        check(32'(pinOe), 32'h00ff);
        check(32'(pinOut), 32'h003c);
        check(32'(weakPullupEn), 32'h0);
        rdchk(`PAC_OFS_LATCH, 32'h003c);
        repeat (3) @(posedge clk);
        rdchk(`PAC_OFS_PORT, 32'ha53c);
        begin
            logic [31:0] unused;
            access(1'b1, `PAC_OFS_LATCH, 16'hffff, 4'b0010, unused);
        end
        rdchk(`PAC_OFS_LATCH, 32'hff3c);
        wr(`PAC_OFS_DIR, 16'hffff);
        check(32'(pinOe), 32'h0);
        wr(6'h30, 16'hffff);
        rdchk(6'h30, 32'h0);
        // pull-ups hold the change inputs high
        wr(`PAC_OFS_PU_LOW, 16'hffff);
        wr(`PAC_OFS_PU_HIGH, 16'h00ff);
        check(32'(weakPullupEn), 32'hffffff);
        rdchk(`PAC_OFS_PU_HIGH, 32'h00ff);
        repeat (4) @(posedge clk);
        foreach (chgIdx[k]) begin
            mask = 24'h1 << chgIdx[k];
            wr(`PAC_OFS_CNEN_LOW, mask[15:0]);
            wr(`PAC_OFS_CNEN_HIGH, {8'h00, mask[23:16]});
            check(32'(changeNotifyReq), 32'h0);
            // only the disabled neighbour moves here
            btnPress <= 24'h1 << (chgIdx[k] ^ 1);
            @(posedge clk);
            btnPress <= 24'h0;
            repeat (4) @(posedge clk);
            check(32'(changeNotifyReq), 32'h0);
            btnPress <= mask | (24'h1 << (chgIdx[k] ^ 1));
            repeat (4) @(posedge clk);
            check(32'(changeNotifyReq), 32'h1);
            rdchk(`PAC_OFS_CHG_STAT, 32'h1);
            wr(`PAC_OFS_CHG_STAT, 16'h0001);
            check(32'(changeNotifyReq), 32'h0);
            btnPress <= 24'h0;
            repeat (4) @(posedge clk);
            check(32'(changeNotifyReq), 32'h1);
            wr(`PAC_OFS_CHG_STAT, 16'h0001);
        end
        complete_run();
    end
endmodule : port_analog_cfg_change_notify_tb_top
